// ---- dv/srco_bench.sv ----
// Bench for the start-up, reset and clock-output block.
`timescale 1ns/100ps
module startup_reset_clock_out_bench;
    // Design ports, named alike for a by-name hook-up.
    logic clk = 0, rst = 1, reset_pin_n = 1, serial_reset_cmd = 0;
    logic clock_output_enable_bit = 1, ctrl_write = 0, sleep_request = 0;
    logic rx_line_activity = 0, wakeup_interrupt_flag = 0, internal_reset;
    logic osc_run_enable, asleep, clock_output_enable_q;
    logic divided_clock_output_pin_o, divided_clock_output_pin_oe_n;
    logic [1:0] divided_clock_output_pin_prescale = 2'h3, divided_clock_output_pin_prescale_q;
    int bad_count = 0, cmp_count = 0, rises, n;
    always #2.5 clk = ~clk;
    srco_top srco_top_inst (.*);
    srco_user srco_user_inst (.pin(divided_clock_output_pin_o), .rises);
    // Judges one settled condition.
    task chk(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t check failed", $time);
        end
    endtask
    task final_report;
        $display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Host waits out the hold, bounded; n counts its cycles.
    task wait_ready;
        for (n = 0; internal_reset !== 1'b0; n++) begin
            if (n > 300) begin chk(0); final_report; end
            @(posedge clk);
        end
    endtask
    task wr(input logic e, input logic [1:0] p);
        clock_output_enable_bit <= e; divided_clock_output_pin_prescale <= p; ctrl_write <= 1;
        @(posedge clk) ctrl_write <= 0;
    endtask
    // Rises per 64 cycles, one cycle of slack for alignment.
    task t_div(input logic [1:0] p);
        wr(1, p); repeat (32) @(posedge clk); n = rises;
        repeat (64) @(posedge clk);
        chk((rises - n - (64 >> p)) inside {-1, 0, 1});
        chk(divided_clock_output_pin_oe_n === 1'b0);
    endtask
    // Sleep drains sixteen cycles; line activity or the flag wakes it.
    task t_sleep(input logic by_flag);
        n = rises; sleep_request <= 1;
        for (int i = 0; i < 400 && asleep !== 1'b1; i++) @(posedge clk);
        chk((rises - n) inside {16, 17} && !divided_clock_output_pin_o);
        sleep_request <= 0;
        if (by_flag) wakeup_interrupt_flag <= 1;
        else rx_line_activity <= 1;
        repeat (4) @(posedge clk);
        rx_line_activity <= 0;
        wakeup_interrupt_flag <= 0;
        repeat (4) @(posedge clk);
        chk(asleep === 1'b0);
        wait_ready; chk(n >= 100);
    endtask
    // Pin reset or serial reset restores the divide-by-eight default.
    task t_rst(input logic pin);
        wr(1, 2'h1); @(posedge clk);
        chk(divided_clock_output_pin_prescale_q === 2'h1);
        reset_pin_n <= !pin; serial_reset_cmd <= !pin;
        repeat (4) @(posedge clk); reset_pin_n <= 1; serial_reset_cmd <= 0;
        repeat (4) @(posedge clk); wait_ready;
        chk(n >= 100 && divided_clock_output_pin_prescale_q === 2'h3);
    endtask
    initial begin
        repeat (5) @(posedge clk); rst <= 0;
        @(posedge clk); wait_ready;
        chk(n >= 120 && divided_clock_output_pin_prescale_q === 2'h3);
        for (int p = 0; p < 4; p++) t_div(p[1:0]);
        wr(0, 2'h3); repeat (20) @(posedge clk);
        chk(divided_clock_output_pin_oe_n === 1'b1);
        wr(1, 2'h3); t_sleep(0); t_sleep(1);
        t_rst(0); t_rst(1); final_report;
    end
endmodule

// ---- dv/srco_props.sv ----
// Checker of start-up and clock-output timing.
`timescale 1ns/100ps
module srco_props (
    // Watched ports
    input wire logic clk, rst, reset_pin_n, serial_reset_cmd, asleep,
    input wire logic rx_line_activity, internal_reset, osc_run_enable,
    input wire logic divided_clock_output_pin_o, clock_output_enable_q,
    input wire logic [1:0] divided_clock_output_pin_prescale_q
);
    // ==========
    // One domain; reset masks every check.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_hold_rst: assert property ($fell(rst) |-> internal_reset[*8])
        else $error("hold");
    a_pin_rst: assert property (!reset_pin_n |-> ##[0:4] internal_reset)
        else $error("pin");
    a_cmd_rst: assert property (serial_reset_cmd |-> ##[0:4]
        internal_reset) else $error("cmd");
    a_dflt_pre: assert property (serial_reset_cmd |=>
        divided_clock_output_pin_prescale_q == 2'h3 && clock_output_enable_q) else $error("dflt");
    a_sleep_low: assert property (asleep |->
        !divided_clock_output_pin_o) else $error("low");
    a_osc_stop: assert property (asleep |-> !osc_run_enable)
        else $error("osc");
    a_rx_wake: assert property (asleep && rx_line_activity |->
        ##[1:8] !asleep) else $error("wake");
    a_div8_high: assert property ($rose(divided_clock_output_pin_o) &&
        divided_clock_output_pin_prescale_q == 2'h3 |-> divided_clock_output_pin_o[*4])
        else $error("div8");
    // Main scenarios.
    c_sleep: cover property (asleep);
    c_wake: cover property ($fell(asleep));
    c_rx: cover property (asleep && rx_line_activity);
endmodule
bind srco_top srco_props srco_props_inst (.*);

// ---- dv/srco_user.sv ----
// Clock-user model: counts output clock rises.
`timescale 1ns/100ps
module srco_user (
    // Pin in, count out
    input wire logic pin,
    output int       rises = 0
);
    // Counted on the pin itself, so divide-by-one shows too.
    always @(posedge pin) rises++;
endmodule

// ---- src/srco_pkg.sv ----
// Package of constants for the start-up, reset and clock-output block.
package srco_pkg;

    // ==========================================================
    // Start-up timer
    localparam int unsigned STARTUP_CYCLES = 128;
    localparam int unsigned STARTUP_CNT_W  = 8;

    // ==========================================================
    // Clock-output prescaler field encodings and reset value
    localparam logic [1:0] PRE_DIV1  = 2'h0;
    localparam logic [1:0] PRE_DIV2  = 2'h1;
    localparam logic [1:0] PRE_DIV4  = 2'h2;
    localparam logic [1:0] PRE_DIV8  = 2'h3;
    localparam logic [1:0] PRE_RESET = PRE_DIV8;
    localparam logic       CLOCK_OUTPUT_ENABLE_BIT_RESET = 1'b1;

    // ==========================================================
    // Sleep hand-off: output cycles emitted after a sleep request
    localparam int unsigned SLEEP_TAIL_CYCLES = 16;
    localparam int unsigned TAIL_CNT_W        = 5;

    // ==========================================================
    // Power state machine, one-hot
    typedef enum logic [3:0] {
        SRCO_ST_STARTUP  = 4'b0001,
        SRCO_ST_RUN      = 4'b0010,
        SRCO_ST_DRAIN    = 4'b0100,
        SRCO_ST_SLEEP    = 4'b1000
    } srco_state_t;

endpackage

// ---- src/srco_sync.sv ----
// Two-flip-flop synchroniser for one asynchronous level.
`timescale 1ns/100ps
module srco_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ---- src/srco_top.sv ----
// Start-up timer, reset merge and glitch-free divided clock output.
`timescale 1ns/100ps

// Summary of operation
// [RQ1] Hold logic reset 128 cycles after any reset
// [RQ2] Host waits for timer before serial access
// [RQ3] Output clock is oscillator divided 1/2/4/8
// [RQ4] After reset output runs divided by eight
// [RQ5] Enable bit low makes output high-impedance
// [RQ6] Sixteen output cycles after sleep request
// [RQ7] Output rests low while asleep; at divide-by-one the pin is still high for the first half cycle of sleep
// [RQ8] Changes only at phase boundaries, no glitches
// [RQ9] Reset pin and serial reset act alike
// [RQ10] System applies one reset after power-up
// [RQ11] Oscillator stopped asleep, restarted on wake-up
// [RQ12] Wake on bus activity or host flag
// [RQ13] Two-bit prescaler field resets to divide-eight
module srco_top (
    // Oscillator clock and power-on reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Reset sources
    input  wire logic       reset_pin_n,
    input  wire logic       serial_reset_cmd,
    // Clock-output control from the controller control register
    input  wire logic       clock_output_enable_bit,
    input  wire logic [1:0] divided_clock_output_pin_prescale,
    input  wire logic       ctrl_write,
    // Sleep and wake-up
    input  wire logic       sleep_request,
    input  wire logic       rx_line_activity,
    input  wire logic       wakeup_interrupt_flag,
    // Outputs
    output logic            internal_reset,
    output logic            osc_run_enable,
    output logic            asleep,
    output logic            divided_clock_output_pin_o,
    output logic            divided_clock_output_pin_oe_n,
    output logic            clock_output_enable_q,
    output logic [1:0]      divided_clock_output_pin_prescale_q
);

    // ==========================================================
    // Pin synchronisation
    logic reset_pin_n_s;
    logic rx_act_s;

    srco_sync #(.RESET_VAL(1'b0)) u_sync_rst (
        .clk      (clk),
        .rst      (rst),
        .async_in (reset_pin_n),
        .sync_out (reset_pin_n_s)
    );

    srco_sync #(.RESET_VAL(1'b0)) u_sync_rx (
        .clk      (clk),
        .rst      (rst),
        .async_in (rx_line_activity),
        .sync_out (rx_act_s)
    );

    // ==========================================================
    // Reset merge: pin low and serial command are equivalent.
    wire soft_reset = ~reset_pin_n_s | serial_reset_cmd; // [RQ9]

    // ==========================================================
    // Control field shadow, defaults after any reset.
    logic       en_q;
    logic [1:0] pre_q;
    logic       en_next;
    logic [1:0] pre_next;

    // The next values are named so that the phase logic can load the
    // setting that takes effect on this very edge; a reset beats a write.
    assign en_next  = soft_reset ? srco_pkg::CLOCK_OUTPUT_ENABLE_BIT_RESET
                    : (ctrl_write ? clock_output_enable_bit : en_q); // [RQ4]
    assign pre_next = soft_reset ? srco_pkg::PRE_RESET
                    : (ctrl_write ? divided_clock_output_pin_prescale : pre_q); // [RQ13]

    // Shadow register of the enable bit and the prescaler field.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q  <= srco_pkg::CLOCK_OUTPUT_ENABLE_BIT_RESET;
            pre_q <= srco_pkg::PRE_RESET; // [RQ13]
        end else begin
            en_q  <= en_next;
            pre_q <= pre_next; // [RQ9]
        end
    end

    // The shadow flops drive the read-back ports directly.
    assign clock_output_enable_q = en_q;
    assign divided_clock_output_pin_prescale_q     = pre_q;

    // ==========================================================
    // Power state machine and start-up timer.
    localparam int unsigned OST_W  = srco_pkg::STARTUP_CNT_W;
    localparam int unsigned TAIL_W = srco_pkg::TAIL_CNT_W;

    // Refuse counts that the counters below cannot reach.
    if (srco_pkg::STARTUP_CYCLES > (2 ** OST_W) ||
        srco_pkg::STARTUP_CYCLES == 0) begin : g_bad_ost
        $error("Start-up count does not fit its counter.");
    end
    if (srco_pkg::SLEEP_TAIL_CYCLES >= (2 ** TAIL_W)) begin : g_bad_tail
        $error("Sleep tail count does not fit its counter.");
    end

    srco_pkg::srco_state_t state_q;
    srco_pkg::srco_state_t state_d;
    logic [OST_W-1:0]      ost_cnt_q;
    logic [OST_W-1:0]      ost_cnt_d;
    logic [TAIL_W-1:0]     tail_cnt_q;
    logic [TAIL_W-1:0]     tail_cnt_d;
    logic                  period_evt;

    // Terminal counts, cut to the counter widths on purpose.
    wire ost_done     = (ost_cnt_q ==
                         OST_W'(srco_pkg::STARTUP_CYCLES - 1)); // [RQ1]
    wire tail_done    = (tail_cnt_q ==
                         TAIL_W'(srco_pkg::SLEEP_TAIL_CYCLES)); // [RQ6]
    wire wake_req     = rx_act_s | wakeup_interrupt_flag; // [RQ12]
    wire in_startup   = (state_q == srco_pkg::SRCO_ST_STARTUP);
    wire in_drain     = (state_q == srco_pkg::SRCO_ST_DRAIN);
    wire stay_startup = in_startup && !soft_reset &&
                        (state_d == srco_pkg::SRCO_ST_STARTUP);

    // Next state; a reset of either kind restarts the start-up timer.
    always_comb begin
        state_d = state_q;
        case (state_q)
            srco_pkg::SRCO_ST_STARTUP: begin
                if (ost_done) begin
                    state_d = srco_pkg::SRCO_ST_RUN; // [RQ1]
                end
            end
            srco_pkg::SRCO_ST_RUN: begin
                if (sleep_request) begin
                    state_d = srco_pkg::SRCO_ST_DRAIN; // [RQ6]
                end
            end
            srco_pkg::SRCO_ST_DRAIN: begin
                // A request once taken is drained even if dropped.
                if (period_evt && tail_done) begin
                    state_d = srco_pkg::SRCO_ST_SLEEP; // [RQ6]
                end
            end
            srco_pkg::SRCO_ST_SLEEP: begin
                if (wake_req) begin
                    state_d = srco_pkg::SRCO_ST_STARTUP; // [RQ12]
                end
            end
            default: begin
                state_d = srco_pkg::SRCO_ST_STARTUP;
            end
        endcase
        if (soft_reset) begin
            state_d = srco_pkg::SRCO_ST_STARTUP; // [RQ9]
        end
    end

    // The timer counts only while the hold lasts, from zero on entry.
    assign ost_cnt_d  = stay_startup ? OST_W'(ost_cnt_q + 1'b1)
                      : '0; // [RQ1]
    // The tail counts whole output periods while draining.
    assign tail_cnt_d = !in_drain ? '0
                      : (period_evt ? TAIL_W'(tail_cnt_q + 1'b1)
                                    : tail_cnt_q); // [RQ6]

    // State and counter registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= srco_pkg::SRCO_ST_STARTUP;
            ost_cnt_q  <= '0;
            tail_cnt_q <= '0;
        end else begin
            state_q    <= state_d;
            ost_cnt_q  <= ost_cnt_d;
            tail_cnt_q <= tail_cnt_d;
        end
    end

    // Status outputs come from flops loaded with the next state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            internal_reset <= 1'b1;
            osc_run_enable <= 1'b1;
            asleep         <= 1'b0;
        end else begin
            internal_reset <= (state_d == srco_pkg::SRCO_ST_STARTUP); // [RQ1]
            osc_run_enable <= (state_d != srco_pkg::SRCO_ST_SLEEP); // [RQ11]
            asleep         <= (state_d == srco_pkg::SRCO_ST_SLEEP); // [RQ7]
        end
    end

    // ==========================================================
    // Glitch-free divider for the clock output.
    logic       div_q;
    logic       div_d;
    logic       bp_q;
    logic       act_en_q;
    logic       act_en_d;
    logic [1:0] act_pre_q;
    logic [1:0] act_pre_d;
    logic [2:0] ph_cnt_q;
    logic [2:0] ph_cnt_d;
    logic       oe_n_q;
    logic       oe_n_d;

    // Length of one phase, less one, for the setting in effect.
    wire [2:0] half_m1 =
        (act_pre_q == srco_pkg::PRE_DIV8) ? 3'h3 :
        (act_pre_q == srco_pkg::PRE_DIV4) ? 3'h1 : 3'h0; // [RQ3]
    wire clk_on   = (state_q != srco_pkg::SRCO_ST_SLEEP); // [RQ11]
    wire boundary = clk_on && (ph_cnt_q == half_m1);
    // New settings load only at the end of a low phase, so neither a
    // high nor a low phase is ever cut short.
    assign period_evt = boundary && !div_q; // [RQ8]
    wire rise_ok  = en_next && (pre_next != srco_pkg::PRE_DIV1) &&
                    (state_d != srco_pkg::SRCO_ST_SLEEP); // [RQ7]
    wire bp_d     = act_en_q && clk_on &&
                    (act_pre_q == srco_pkg::PRE_DIV1); // [RQ3]

    assign ph_cnt_d  = boundary ? 3'h0
                     : (clk_on ? 3'(ph_cnt_q + 3'h1) : 3'h0);
    assign div_d     = !clk_on ? 1'b0
                     : (boundary ? (!div_q && rise_ok) : div_q); // [RQ8]
    assign act_en_d  = period_evt ? en_next : act_en_q;
    assign act_pre_d = period_evt ? pre_next : act_pre_q;
    assign oe_n_d    = period_evt ? ~en_next : oe_n_q; // [RQ5]

    // Divider phase registers; the setting in effect lags the shadow.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_cnt_q  <= 3'h0;
            div_q     <= 1'b0;
            act_en_q  <= srco_pkg::CLOCK_OUTPUT_ENABLE_BIT_RESET;
            act_pre_q <= srco_pkg::PRE_RESET; // [RQ4]
            oe_n_q    <= ~srco_pkg::CLOCK_OUTPUT_ENABLE_BIT_RESET;
        end else begin
            ph_cnt_q  <= ph_cnt_d;
            div_q     <= div_d;
            act_en_q  <= act_en_d;
            act_pre_q <= act_pre_d;
            oe_n_q    <= oe_n_d;
        end
    end

    // Divide-by-one cannot come from a flop on this clock alone: the
    // clock itself is gated by a flop that changes only while it is
    // low, which keeps the gated output free of runt pulses.
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            bp_q <= 1'b0;
        end else begin
            bp_q <= bp_d;
        end
    end

    // Pin level and its enable; idle low when stopped, and in sleep except a first high half cycle at divide-by-one.
    assign divided_clock_output_pin_o    = (clk & bp_q) | div_q; // [RQ3]
    assign divided_clock_output_pin_oe_n = oe_n_q; // [RQ5]

endmodule
